// ==== dtc_pkg.sv ====
// Package of constants and types for the dual eight-bit timer control block.
package dtc_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_CTRL0 = 16'hffb0;
  localparam logic [15:0] IDX_CTRL1 = 16'hffb1;
  localparam logic [15:0] IDX_STAT0 = 16'hffb2;
  localparam logic [15:0] IDX_STAT1 = 16'hffb3;
  localparam logic [15:0] IDX_CONA0 = 16'hffb4;
  localparam logic [15:0] IDX_CONA1 = 16'hffb5;
  localparam logic [15:0] IDX_CONB0 = 16'hffb6;
  localparam logic [15:0] IDX_CONB1 = 16'hffb7;
  localparam logic [15:0] IDX_CNT0 = 16'hffb8;
  localparam logic [15:0] IDX_CNT1 = 16'hffb9;
  localparam logic [15:0] IDX_ISTAT = 16'hffba;
  localparam logic [15:0] IDX_IMASK = 16'hffbb;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int CTRL_MBIE = 7;
  localparam int CTRL_MAIE = 6;
  localparam int CTRL_OVERFLOW_IRQ_ENABLE = 5;
  localparam int CTRL_CCLR_HI = 4;
  localparam int CTRL_CCLR_LO = 3;
  localparam int CTRL_CKS_HI = 2;
  localparam int CTRL_CKS_LO = 0;
  localparam int STAT_MBF = 7;
  localparam int STAT_MAF = 6;
  localparam int STAT_OVF = 5;
  localparam int ISTAT_W = 6;
  localparam int IRQ_PER_CH = 3;

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] CONST_RST = 8'hff;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [5:0] ISTAT_RST = 6'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Prescaler: taps for the divide-by-8, 64 and 8192 clocks.
  // ----------------------------------------------------------------------
  localparam int PRE_W = 13;
  localparam int PRE8_MSB = 2;
  localparam int PRE64_MSB = 5;
  localparam int PRE8192_MSB = 12;

  // ----------------------------------------------------------------------
  // Modes.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CKS_OFF,
    CKS_DIV8,
    CKS_DIV64,
    CKS_DIV8192,
    CKS_CASCADE,
    CKS_EXT_RISE,
    CKS_EXT_FALL,
    CKS_EXT_BOTH
  } dtc_cks_t;

  typedef enum logic [1:0] {
    CCLR_NONE,
    CCLR_MATCH_A,
    CCLR_MATCH_B,
    CCLR_EXT
  } dtc_cclr_t;

endpackage : dtc_pkg

// ==== dtc_channel.sv ====
// One timer channel: count clock selection, counter, compares and clears.
`timescale 1ns/1ps
module dtc_channel
  import dtc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [2:0] cks,
  input wire logic [1:0] cclr,
  input wire logic tick8,
  input wire logic tick64,
  input wire logic tick8192,
  input wire logic cascade_evt,
  input wire logic ext_clk,
  input wire logic ext_rst,
  input wire logic [7:0] const_a,
  input wire logic [7:0] const_b,
  input wire logic cnt_we,
  input wire logic [7:0] cnt_wdata,
  output logic [7:0] count,
  output logic match_a,
  output logic match_b,
  output logic ovf
);

  // ----------------------------------------------------------------------
  // Count enable selection.
  // ----------------------------------------------------------------------
  logic ext_clk_r;
  logic ext_rst_r;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic ma_r;
  logic ma_nxt;
  logic mb_r;
  logic mb_nxt;
  logic ov_r;
  logic ov_nxt;
  logic inc;
  logic clr;
  logic ext_rise;
  logic ext_fall;

  always_comb begin
    ext_rise = ext_clk & ~ext_clk_r;
    ext_fall = ~ext_clk & ext_clk_r;
    case (dtc_cks_t'(cks))
      CKS_DIV8: inc = tick8;
      CKS_DIV64: inc = tick64;
      CKS_DIV8192: inc = tick8192;
      CKS_CASCADE: inc = cascade_evt;
      CKS_EXT_RISE: inc = ext_rise;
      CKS_EXT_FALL: inc = ext_fall;
      CKS_EXT_BOTH: inc = ext_rise | ext_fall;
      default: inc = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Counter and events.
  // ----------------------------------------------------------------------
  // A match clears the counter on the cycle after the match is flagged, so
  // the matched value is seen for one cycle before the restart.
  always_comb begin
    case (dtc_cclr_t'(cclr))
      CCLR_MATCH_A: clr = ma_r;
      CCLR_MATCH_B: clr = mb_r;
      CCLR_EXT: clr = ext_rst & ~ext_rst_r;
      default: clr = 1'b0;
    endcase
    count_nxt = count_r;
    ov_nxt = 1'b0;
    if (cnt_we) begin
      count_nxt = cnt_wdata;
    end else if (clr) begin
      count_nxt = CNT_RST;
    end else if (inc) begin
      count_nxt = count_r + 8'h01;
      ov_nxt = &count_r;
    end
    ma_nxt = (count_nxt == const_a) && (count_nxt != count_r);
    mb_nxt = (count_nxt == const_b) && (count_nxt != count_r);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ext_clk_r <= 1'b0;
      ext_rst_r <= 1'b0;
      count_r <= CNT_RST;
      ma_r <= 1'b0;
      mb_r <= 1'b0;
      ov_r <= 1'b0;
    end else begin
      ext_clk_r <= ext_clk;
      ext_rst_r <= ext_rst;
      count_r <= count_nxt;
      ma_r <= ma_nxt;
      mb_r <= mb_nxt;
      ov_r <= ov_nxt;
    end
  end

  assign count = count_r;
  assign match_a = ma_r;
  assign match_b = mb_r;
  assign ovf = ov_r;

endmodule : dtc_channel

// ==== dtc_timer_top.sv ====
// Top of the dual eight-bit timer control block with its APB register file.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - An internal clock setting counts on the falling edge of the clock divided by 8, 64 or 8192.
// - External rising-edge setting counts each rising edge of the channel's external clock.
// - External falling-edge setting counts each falling edge of the channel's external clock.
// - Dual-edge setting counts both edges of the channel's external clock.
// - In cascade, channel zero counts on each overflow of channel one.
// - In cascade, channel one counts on each compare match A of channel zero.
// - The match B interrupt enable passes the match B request when 1 and blocks it when 0.
// - Status flags in bits 7 to 5 are cleared by writing 0 and ignore writes of 1.
module dtc_timer_top
  import dtc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_CLK0,
  input wire logic EXT_CLK1,
  input wire logic EXT_RST0,
  input wire logic EXT_RST1,
  output logic IRQ
);

  // ----------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_r [2];
  logic [7:0] ctrl_nxt [2];
  logic [7:0] stat_r [2];
  logic [7:0] stat_nxt [2];
  logic [7:0] cona_r [2];
  logic [7:0] cona_nxt [2];
  logic [7:0] conb_r [2];
  logic [7:0] conb_nxt [2];
  logic [ISTAT_W-1:0] istat_r;
  logic [ISTAT_W-1:0] istat_nxt;
  logic [ISTAT_W-1:0] imask_r;
  logic [ISTAT_W-1:0] imask_nxt;
  logic [ISTAT_W-1:0] ireq;
  logic irq_r;
  logic irq_nxt;

  // ----------------------------------------------------------------------
  // Bus state.
  // ----------------------------------------------------------------------
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic acc;
  logic wr;
  logic rd;
  logic [15:0] idx;
  logic mapped;

  // ----------------------------------------------------------------------
  // Prescaler.
  // ----------------------------------------------------------------------
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic tick8_r;
  logic tick64_r;
  logic tick8192_r;
  logic tick8_nxt;
  logic tick64_nxt;
  logic tick8192_nxt;

  // ----------------------------------------------------------------------
  // Channel links.
  // ----------------------------------------------------------------------
  logic [7:0] count [2];
  logic [1:0] ev_ma;
  logic [1:0] ev_mb;
  logic [1:0] ev_ov;
  logic [1:0] cascade;
  logic [1:0] ext_clk;
  logic [1:0] ext_rst;
  logic [1:0] cnt_we;
  logic [1:0] wr_ctrl;
  logic [1:0] wr_stat;
  logic [1:0] wr_cona;
  logic [1:0] wr_conb;

  // The divided clock falls when its low prescaler bits all wrap to zero,
  // so the tick is raised on the cycle of the wrap.
  always_comb begin
    pre_nxt = pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
    tick8_nxt = &pre_r[PRE8_MSB:0];
    tick64_nxt = &pre_r[PRE64_MSB:0];
    tick8192_nxt = &pre_r[PRE8192_MSB:0];
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pre_r <= {PRE_W{1'b0}};
      tick8_r <= 1'b0;
      tick64_r <= 1'b0;
      tick8192_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      tick8_r <= tick8_nxt;
      tick64_r <= tick64_nxt;
      tick8192_r <= tick8192_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Channels.
  // ----------------------------------------------------------------------
  // Events leave each channel from a flip-flop, so the cross-coupled
  // cascade never closes a combinational loop; it costs one cycle of lag.
  assign cascade[0] = ev_ov[1];
  assign cascade[1] = ev_ma[0];
  assign ext_clk[0] = EXT_CLK0;
  assign ext_clk[1] = EXT_CLK1;
  assign ext_rst[0] = EXT_RST0;
  assign ext_rst[1] = EXT_RST1;

  // Write strobes are decoded once per channel and shared below.
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      assign cnt_we[ch] = wr && (idx == IDX_CNT0 + 16'(ch));
      assign wr_ctrl[ch] = wr && (idx == IDX_CTRL0 + 16'(ch));
      assign wr_stat[ch] = wr && (idx == IDX_STAT0 + 16'(ch));
      assign wr_cona[ch] = wr && (idx == IDX_CONA0 + 16'(ch));
      assign wr_conb[ch] = wr && (idx == IDX_CONB0 + 16'(ch));
      dtc_channel u_ch (
        .clock(CLOCK),
        .resetn(RESETN),
        .cks(ctrl_r[ch][CTRL_CKS_HI:CTRL_CKS_LO]),
        .cclr(ctrl_r[ch][CTRL_CCLR_HI:CTRL_CCLR_LO]),
        .tick8(tick8_r),
        .tick64(tick64_r),
        .tick8192(tick8192_r),
        .cascade_evt(cascade[ch]),
        .ext_clk(ext_clk[ch]),
        .ext_rst(ext_rst[ch]),
        .const_a(cona_r[ch]),
        .const_b(conb_r[ch]),
        .cnt_we(cnt_we[ch]),
        .cnt_wdata(PWDATA[7:0]),
        .count(count[ch]),
        .match_a(ev_ma[ch]),
        .match_b(ev_mb[ch]),
        .ovf(ev_ov[ch])
      );
      assign ireq[IRQ_PER_CH*ch] = ev_ma[ch] & ctrl_r[ch][CTRL_MAIE];
      assign ireq[IRQ_PER_CH*ch+1] = ev_mb[ch] & ctrl_r[ch][CTRL_MBIE];
      assign ireq[IRQ_PER_CH*ch+2] = ev_ov[ch] & ctrl_r[ch][CTRL_OVERFLOW_IRQ_ENABLE];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------------
  // One wait state: the answer is prepared in the first access cycle and
  // shown from flip-flops in the second.
  // The interrupt status is read from its next value, so an event in the
  // preparing cycle is shown before the read clears it, never lost unseen.
  // A refused access returns zero data.
  always_comb begin
    idx = PADDR[ADDR_W-1:2];
    mapped = (PADDR[1:0] == 2'b00) && (idx >= IDX_CTRL0) &&
             (idx <= IDX_IMASK);
    acc = PSEL & PENABLE & pready_r;
    wr = acc & PWRITE & mapped;
    rd = acc & ~PWRITE & mapped;
    pready_nxt = PSEL & PENABLE & ~pready_r;
    pslverr_nxt = pready_nxt & ~mapped;
    prdata_nxt = RDATA_RST;
    if (pready_nxt && !PWRITE && mapped) begin
      case (idx)
        IDX_CTRL0: prdata_nxt[7:0] = ctrl_r[0];
        IDX_CTRL1: prdata_nxt[7:0] = ctrl_r[1];
        IDX_STAT0: prdata_nxt[7:0] = stat_r[0];
        IDX_STAT1: prdata_nxt[7:0] = stat_r[1];
        IDX_CONA0: prdata_nxt[7:0] = cona_r[0];
        IDX_CONA1: prdata_nxt[7:0] = cona_r[1];
        IDX_CONB0: prdata_nxt[7:0] = conb_r[0];
        IDX_CONB1: prdata_nxt[7:0] = conb_r[1];
        IDX_CNT0: prdata_nxt[7:0] = count[0];
        IDX_CNT1: prdata_nxt[7:0] = count[1];
        IDX_ISTAT: prdata_nxt[ISTAT_W-1:0] = istat_nxt;
        IDX_IMASK: prdata_nxt[ISTAT_W-1:0] = imask_r;
        default: prdata_nxt = RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= RDATA_RST;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Channel registers.
  // ----------------------------------------------------------------------
  // A flag event in the cycle of a clearing write keeps the flag set.
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      ctrl_nxt[ch] = ctrl_r[ch];
      cona_nxt[ch] = cona_r[ch];
      conb_nxt[ch] = conb_r[ch];
      stat_nxt[ch] = stat_r[ch];
      if (wr_ctrl[ch]) begin
        ctrl_nxt[ch] = PWDATA[7:0];
      end
      if (wr_cona[ch]) begin
        cona_nxt[ch] = PWDATA[7:0];
      end
      if (wr_conb[ch]) begin
        conb_nxt[ch] = PWDATA[7:0];
      end
      if (wr_stat[ch]) begin
        stat_nxt[ch][STAT_MBF] = stat_r[ch][STAT_MBF] & PWDATA[STAT_MBF];
        stat_nxt[ch][STAT_MAF] = stat_r[ch][STAT_MAF] & PWDATA[STAT_MAF];
        stat_nxt[ch][STAT_OVF] = stat_r[ch][STAT_OVF] & PWDATA[STAT_OVF];
      end
      if (ev_mb[ch]) begin
        stat_nxt[ch][STAT_MBF] = 1'b1;
      end
      if (ev_ma[ch]) begin
        stat_nxt[ch][STAT_MAF] = 1'b1;
      end
      if (ev_ov[ch]) begin
        stat_nxt[ch][STAT_OVF] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      for (int ch = 0; ch < 2; ch++) begin
        ctrl_r[ch] <= CTRL_RST;
        stat_r[ch] <= STAT_RST;
        cona_r[ch] <= CONST_RST;
        conb_r[ch] <= CONST_RST;
      end
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        ctrl_r[ch] <= ctrl_nxt[ch];
        stat_r[ch] <= stat_nxt[ch];
        cona_r[ch] <= cona_nxt[ch];
        conb_r[ch] <= conb_nxt[ch];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts.
  // ----------------------------------------------------------------------
  // Reading the status clears it, but a request in the same cycle stays.
  always_comb begin
    istat_nxt = istat_r;
    imask_nxt = imask_r;
    if (rd && idx == IDX_ISTAT) begin
      istat_nxt = ISTAT_RST;
    end
    istat_nxt = istat_nxt | ireq;
    if (wr && idx == IDX_IMASK) begin
      imask_nxt = PWDATA[ISTAT_W-1:0];
    end
    irq_nxt = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      istat_r <= ISTAT_RST;
      imask_r <= ISTAT_RST;
      irq_r <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign IRQ = irq_r;

endmodule : dtc_timer_top

// ==== dtc_timer_checker.sv ====
// Checker of the timer block's register bus and interrupt output.
`timescale 1ns/1ps
module dtc_timer_checker
  import dtc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic EXT_CLK0,
  input wire logic EXT_CLK1,
  input wire logic EXT_RST0,
  input wire logic EXT_RST1,
  input wire logic IRQ
);
  // ----
  // Helper logic.
  // ----
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  logic [15:0] idx;
  logic done;
  logic mapped;
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl0_nxt;
  assign idx = PADDR[ADDR_W-1:2];
  assign done = PSEL && PENABLE && PREADY;
  assign mapped = PADDR[1:0] == 2'b00 && idx >= IDX_CTRL0 && idx <= IDX_IMASK;
  // A shadow of the control word, so a read-back can be judged.
  always_comb begin
    ctrl0_nxt = ctrl0_r;
    if (done && PWRITE && mapped && idx == IDX_CTRL0) ctrl0_nxt = PWDATA[7:0];
  end
  always_ff @(posedge CLOCK) begin
    if (!RESETN) ctrl0_r <= CTRL_RST;
    else ctrl0_r <= ctrl0_nxt;
  end
  // ----
  // Properties.
  // ----
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_answer;
    PSEL && PENABLE && !PREADY ##1 PSEL && PENABLE && PREADY;
  endsequence
  property p_one_wait;
    s_setup |=> s_answer;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("late ready");
  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  property p_idle_quiet;
    !PSEL |-> !PREADY && !PSLVERR;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle answer");
  property p_err_bad;
    done && !mapped |-> PSLVERR;
  endproperty
  a_err_bad: assert property (p_err_bad) else $error("missing error");
  property p_ok_mapped;
    done && mapped |-> !PSLVERR;
  endproperty
  a_ok_mapped: assert property (p_ok_mapped) else $error("false error");
  property p_err_rdata;
    done && PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000;
  endproperty
  a_err_rdata: assert property (p_err_rdata) else $error("error data");
  property p_rdata_hi;
    done && !PWRITE |-> PRDATA[31:8] == 24'h00_0000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper data");
  property p_stat_low;
    done && !PWRITE && mapped && (idx == IDX_STAT0 || idx == IDX_STAT1)
      |-> PRDATA[4:0] == 5'h00;
  endproperty
  a_stat_low: assert property (p_stat_low) else $error("status low bits");
  property p_ctrl_back;
    done && !PWRITE && mapped && idx == IDX_CTRL0 |-> PRDATA[7:0] == ctrl0_r;
  endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("control value");
  property p_mask_off;
    done && PWRITE && mapped && idx == IDX_IMASK && PWDATA[5:0] == 6'h00
      |=> ##1 (!IRQ)[*3];
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq");
endmodule : dtc_timer_checker

bind dtc_timer_top dtc_timer_checker u_chk (.CLOCK(CLOCK), .RESETN(RESETN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .EXT_CLK0(EXT_CLK0), .EXT_CLK1(EXT_CLK1), .EXT_RST0(EXT_RST0),
  .EXT_RST1(EXT_RST1), .IRQ(IRQ));

// ==== tb.sv ====
// Self-checking bench of the dual eight-bit timer control block.
`timescale 1ns/1ps
module tb
  import dtc_pkg::*;
;
  // ----
  // Signals and tasks.
  // ----
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [1:0] ext_clk = 2'b00;
  logic [1:0] ext_rst = 2'b00;
  logic [31:0] rdata;
  logic rerr;
  int n_fail = 0;
  int compares = 0;
  int p;
  int e;
  int div[3] = '{8, 64, 8192};

  always #12.5 clock = ~clock;

  dtc_timer_top DUT (.CLOCK(clock), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_CLK0(ext_clk[0]), .EXT_CLK1(ext_clk[1]), .EXT_RST0(ext_rst[0]),
    .EXT_RST1(ext_rst[1]), .IRQ(irq));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // The request is held until ready is seen; the wait is bounded.
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    check({7'h00, pready}, 8'h01, "ready");
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp,
                     input string what);
    apb(1'b0, idx, 8'h00);
    check(rdata[7:0], exp, what);
  endtask : rdc

  task automatic pulse(input int ch, input int cnt);
    repeat (cnt) begin
      ext_clk[ch] <= 1'b1;
      repeat (4) @(posedge clock);
      ext_clk[ch] <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask : pulse

  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    complete_run();
  end

  // ----
  // Scenarios.
  // ----
  initial begin
    void'($urandom(32'h0000_8752));
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rdc(IDX_CTRL0, CTRL_RST, "ctrl0 reset");
    rdc(IDX_CTRL1, CTRL_RST, "ctrl1 reset");
    apb(1'b0, IDX_IMASK + 16'h0001, 8'h00);
    check({7'h00, rerr}, 8'h01, "unmapped error");
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 5; m < 8; m++) begin
        p = $urandom_range(20, 1);
        wr(IDX_CNT0 + 16'(ch), 8'h00);
        wr(IDX_CTRL0 + 16'(ch), 8'(m));
        pulse(ch, p);
        // The pin is left high so rise and fall modes differ by one.
        ext_clk[ch] <= 1'b1;
        repeat (4) @(posedge clock);
        wr(IDX_CTRL0 + 16'(ch), 8'h00);
        ext_clk[ch] <= 1'b0;
        e = (m == 5) ? p + 1 : (m == 6) ? p : 2 * p + 1;
        rdc(IDX_CNT0 + 16'(ch), 8'(e), "ext count");
      end
    end
    // The prescaler runs free, so one tick of slack is allowed.
    for (int m = 1; m < 4; m++) begin
      wr(IDX_CNT0, 8'h00);
      wr(IDX_CTRL0, 8'(m));
      repeat (2 * div[m - 1]) @(posedge clock);
      wr(IDX_CTRL0, 8'h00);
      apb(1'b0, IDX_CNT0, 8'h00);
      check({7'h00, (rdata[7:0] inside {8'h02, 8'h03})}, 8'h01,
            "tick");
    end
    wr(IDX_CONA0, 8'h03);
    wr(IDX_CONB0, 8'h05);
    for (int c = 0; c < 4; c++) begin
      p = $urandom_range(12, 6);
      wr(IDX_CNT0, 8'h00);
      wr(IDX_CTRL0, 8'(c * 8 + 5));
      pulse(0, p);
      ext_rst[0] <= 1'b1;
      repeat (4) @(posedge clock);
      ext_rst[0] <= 1'b0;
      pulse(0, 1);
      e = (c == 0) ? p + 1 : (c == 1) ? (p % 3 + 1) % 3 :
          (c == 2) ? (p % 5 + 1) % 5 : 1;
      rdc(IDX_CNT0, 8'(e), "clear mode");
      if (c == 0) begin
        wr(IDX_STAT0, 8'hff);
        rdc(IDX_STAT0, 8'hc0, "flags kept");
        wr(IDX_STAT0, 8'h40);
        rdc(IDX_STAT0, 8'h40, "flag b cleared");
        wr(IDX_STAT0, 8'h00);
        rdc(IDX_STAT0, 8'h00, "flags cleared");
      end
    end
    wr(IDX_CONA0, 8'hff);
    wr(IDX_CONB0, 8'h02);
    wr(IDX_IMASK, 8'h3f);
    for (int b = 0; b < 2; b++) begin
      wr(IDX_CNT0, 8'h00);
      wr(IDX_CTRL0, 8'(b * 128 + 5));
      pulse(0, 2);
      check({7'h00, irq}, 8'(b), "irq level");
      if (b == 1) begin
        wr(IDX_IMASK, 8'h00);
        check({7'h00, irq}, 8'h00, "irq masked");
        wr(IDX_IMASK, 8'h3f);
      end
      rdc(IDX_ISTAT, 8'(b * 2), "irq status");
      check({7'h00, irq}, 8'h00, "irq after read");
    end
    wr(IDX_CONA0, 8'h02);
    wr(IDX_CNT0, 8'h00);
    wr(IDX_CNT1, 8'h00);
    wr(IDX_CTRL1, 8'h04);
    wr(IDX_CTRL0, 8'h0d);
    pulse(0, 6);
    rdc(IDX_CNT1, 8'h03, "cascade ch1");
    wr(IDX_CTRL0, 8'h04);
    wr(IDX_CONA1, 8'h10);
    wr(IDX_CONB1, 8'h10);
    wr(IDX_CNT1, 8'hfe);
    wr(IDX_CNT0, 8'h00);
    wr(IDX_STAT1, 8'h00);
    wr(IDX_CTRL1, 8'h05);
    pulse(1, 3);
    rdc(IDX_CNT0, 8'h01, "cascade ch0");
    rdc(IDX_STAT1, 8'h20, "overflow flag");
    rdc(IDX_CTRL1, 8'h05, "ctrl1 value");
    complete_run();
  end
endmodule : tb
